// ---- shared/mem_map_pkg.sv ----
// Package for the flash/SRAM memory subsystem: map, array geometry,
// reset values and the core and programming carriers.
// Assumes one core clock domain; addresses are 32-bit byte addresses.
`default_nettype none

package mem_map_pkg;

    // Region placement in the flat byte space
    localparam logic [31:0] ALIAS_BASE = 32'h0000_0000;
    localparam logic [31:0] SRAM_BASE = 32'h0001_0000;
    localparam logic [31:0] FLASH_BASE = 32'h0008_0000;
    localparam int FLASH_WIN_BITS = 16; // 64 KiB flash window
    localparam int SRAM_WIN_BITS = 13; // 8 KiB SRAM window

    // Flash: 32k x 16, last 1k halfwords hold the boot kernel
    localparam int FLASH_AW = 15;
    localparam int FLASH_WORDS = 32768;
    localparam int FLASH_DW = 16;
    localparam logic [14:0] KERNEL_FIRST = 15'h7C00;
    localparam int PAGE_HW_BITS = 8; // 512-byte page = 256 halfwords
    localparam logic [7:0] PAGE_LAST = 8'hFF;
    localparam logic [15:0] ERASED_HW = 16'hFFFF;

    // SRAM: 2k x 32
    localparam int SRAM_AW = 11;
    localparam int SRAM_WORDS = 2048;

    // Flash at address zero after any reset
    localparam logic ALIAS_FLASH_RESET = 1'b1;

    typedef enum logic [1:0] {SZ_BYTE, SZ_HALF, SZ_WORD} size_e;
    typedef enum logic [1:0] {RG_NONE, RG_FLASH, RG_SRAM} region_e;

    typedef struct packed {
        logic valid;
        logic write;
        size_e size;
        logic [31:0] addr;
        logic [31:0] wdata;
    } core_req_s;

    typedef struct packed {
        logic valid;
        logic err;
        logic [31:0] rdata;
    } core_resp_s;

    typedef struct packed {
        logic valid;
        logic erase;
        logic [14:0] hw_addr;
        logic [15:0] data;
    } prog_cmd_s;

endpackage : mem_map_pkg

`default_nettype wire

// ---- logic/mem_subsystem.sv ----
// Memory subsystem: decodes core accesses to flash and SRAM, aliases one
// of them at address zero, and serves a simple flash programming port.
// Assumes the core holds a request stable until core_ready takes it.
//
// Contract
// - After any reset, flash appears at address zero.
// - Clearing alias-select bit 0 maps SRAM at address zero instead.
// - One flat 32-bit byte space; each memory at its own fixed region.
// - Multi-byte values little-endian; lowest address holds least significant byte.
// - Flash is 32k halfwords; last 1k halfwords reserved for boot kernel.
// - Flash erases in 512-byte pages aligned to the page size.
// - A 32-bit flash fetch takes two consecutive halfword reads.
// - Halfword flash reads at full rate; word fetches at half rate.
// - SRAM is 2k words of 32 bits; reads whole words, writes by byte lane.
// - SRAM serves words every cycle with no extra wait states.
// - Flash user region serves code and data from one address space.
`default_nettype none

module mem_subsystem
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic alias_wr,
    input wire logic alias_bit0,
    input wire mem_map_pkg::core_req_s req,
    output mem_map_pkg::core_resp_s resp,
    output logic core_ready,
    input wire mem_map_pkg::prog_cmd_s prog,
    output logic prog_busy,
    output logic alias_is_flash
);

    typedef enum {ST_IDLE, ST_FLASH_HI, ST_ERASE} state_e;

    state_e state;
    state_e next_state;
    logic [15:0] flash_mem [mem_map_pkg::FLASH_WORDS];
    logic [31:0] sram_mem [mem_map_pkg::SRAM_WORDS];
    logic [15:0] lo_half;
    logic [14:0] hi_idx;
    logic [14:0] erase_ptr;
    mem_map_pkg::core_resp_s next_resp;

    // Region of an address under the current alias choice
    function automatic mem_map_pkg::region_e region_of(
        input logic [31:0] a, input logic to_flash);
        if (a[31:mem_map_pkg::FLASH_WIN_BITS] ==
            mem_map_pkg::ALIAS_BASE[31:mem_map_pkg::FLASH_WIN_BITS])
            region_of = to_flash ? mem_map_pkg::RG_FLASH
                                 : mem_map_pkg::RG_SRAM;
        else if (a[31:mem_map_pkg::FLASH_WIN_BITS] ==
                 mem_map_pkg::FLASH_BASE[31:mem_map_pkg::FLASH_WIN_BITS])
            region_of = mem_map_pkg::RG_FLASH;
        else if (a[31:mem_map_pkg::SRAM_WIN_BITS] ==
                 mem_map_pkg::SRAM_BASE[31:mem_map_pkg::SRAM_WIN_BITS])
            region_of = mem_map_pkg::RG_SRAM;
        else
            region_of = mem_map_pkg::RG_NONE;
    endfunction : region_of

    // Byte lanes touched by an access, least significant lane lowest
    function automatic logic [3:0] lanes_of(
        input mem_map_pkg::size_e sz, input logic [1:0] a);
        case (sz)
            mem_map_pkg::SZ_BYTE: lanes_of = 4'h1 << a;
            mem_map_pkg::SZ_HALF: lanes_of = a[1] ? 4'hC : 4'h3;
            default: lanes_of = 4'hF;
        endcase
    endfunction : lanes_of

    // Decode of the request in front of the subsystem
    wire logic accept = req.valid && (state == ST_IDLE);
    wire mem_map_pkg::region_e req_region = region_of(req.addr,
                                                      alias_is_flash);
    wire logic [14:0] req_hw_idx = req.addr[15:1];
    wire logic [14:0] lo_idx = {req.addr[15:2], 1'b0};
    wire logic [10:0] sram_idx = req.addr[12:2];
    wire logic [3:0] lanes = lanes_of(req.size, req.addr[1:0]);
    wire logic is_word = (req.size == mem_map_pkg::SZ_WORD);
    wire logic flash_rd = accept && !req.write &&
                          (req_region == mem_map_pkg::RG_FLASH);
    wire logic sram_acc = accept && (req_region == mem_map_pkg::RG_SRAM);
    wire logic [15:0] flash_hw = flash_mem[req_hw_idx];

    // Programming port: taken only when idle and no core request waits
    wire logic prog_take = prog.valid && (state == ST_IDLE) && !req.valid;
    wire logic prog_user = prog.hw_addr < mem_map_pkg::KERNEL_FIRST;
    wire logic prog_wr = prog_take && !prog.erase && prog_user;
    wire logic erase_go = prog_take && prog.erase && prog_user;
    wire logic erase_end = erase_ptr[mem_map_pkg::PAGE_HW_BITS-1:0] ==
                           mem_map_pkg::PAGE_LAST;

    // Sequencer: word flash reads take a second cycle
    always_comb
    begin
        next_state = state;
        case (state)
            ST_IDLE:
            begin
                if (flash_rd && is_word)
                    next_state = ST_FLASH_HI;
                else if (erase_go)
                    next_state = ST_ERASE;
            end
            ST_FLASH_HI: next_state = ST_IDLE;
            ST_ERASE: next_state = erase_end ? ST_IDLE : ST_ERASE;
            default: next_state = ST_IDLE;
        endcase
    end

    // Answer to the core, registered before it leaves
    always_comb
    begin
        next_resp = '0;
        if (state == ST_FLASH_HI)
        begin
            next_resp.valid = 1'b1;
            next_resp.rdata = {flash_mem[hi_idx], lo_half};
        end
        else if (accept)
        begin
            next_resp.valid = !(flash_rd && is_word);
            if (sram_acc && !req.write)
                next_resp.rdata = sram_mem[sram_idx];
            else if (flash_rd)
                next_resp.rdata = {flash_hw, flash_hw};
            next_resp.err = (req_region == mem_map_pkg::RG_NONE) ||
                            (req.write && !sram_acc);
        end
    end

    // Control state
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            state <= ST_IDLE;
            resp <= '0;
            core_ready <= 1'b1;
            prog_busy <= 1'b0;
            alias_is_flash <= mem_map_pkg::ALIAS_FLASH_RESET;
            lo_half <= '0;
            hi_idx <= '0;
            erase_ptr <= '0;
        end
        else
        begin
            state <= next_state;
            resp <= next_resp;
            core_ready <= (next_state == ST_IDLE);
            prog_busy <= (next_state == ST_ERASE);
            if (alias_wr)
                alias_is_flash <= alias_bit0;
            if (flash_rd && is_word)
            begin
                lo_half <= flash_mem[lo_idx];
                hi_idx <= lo_idx | 15'h0001;
            end
            if (erase_go)
                erase_ptr <= {prog.hw_addr[14:mem_map_pkg::PAGE_HW_BITS],
                              {mem_map_pkg::PAGE_HW_BITS{1'b0}}};
            else if (state == ST_ERASE)
                erase_ptr <= erase_ptr + 15'h0001;
        end
    end

    // Flash array: programming writes and page erase, one halfword a cycle
    always_ff @(posedge ref_clk)
    begin
        if (prog_wr)
            flash_mem[prog.hw_addr] <= prog.data;
        else if (state == ST_ERASE)
            flash_mem[erase_ptr] <= mem_map_pkg::ERASED_HW;
    end

    // SRAM array: byte-lane writes, lane 0 at the lowest address
    always_ff @(posedge ref_clk)
    begin
        for (int i = 0; i < 4; i++)
            if (sram_acc && req.write && lanes[i])
                sram_mem[sram_idx][8*i +: 8] <= req.wdata[8*i +: 8];
    end

    // Checks on the behaviour above
    sequence flash_word_take;
        accept && flash_rd && is_word;
    endsequence

    sequence single_take;
        accept && !(flash_rd && is_word);
    endsequence

    AST_ALIAS_RESET: assert property (@(posedge ref_clk)
        $fell(sys_rst) |-> alias_is_flash)
        else $error("flash not aliased at zero after reset");

    AST_ALIAS_CLEAR: assert property (@(posedge ref_clk)
        disable iff (sys_rst) alias_wr && !alias_bit0 |=> !alias_is_flash)
        else $error("alias bit clear did not select SRAM");

    AST_ZERO_REGION: assert property (@(posedge ref_clk)
        disable iff (sys_rst) req.addr[31:16] == 16'h0000 |->
        (req_region == (alias_is_flash ? mem_map_pkg::RG_FLASH
                                       : mem_map_pkg::RG_SRAM)))
        else $error("address zero decoded to wrong memory");

    AST_WORD_TWO_READS: assert property (@(posedge ref_clk)
        disable iff (sys_rst) flash_word_take |=> !resp.valid ##1 resp.valid)
        else $error("flash word not answered after two reads");

    AST_WAIT_STATE: assert property (@(posedge ref_clk)
        disable iff (sys_rst) flash_word_take |=> !core_ready ##1 core_ready)
        else $error("core not held during second flash read");

    AST_SINGLE_CYCLE: assert property (@(posedge ref_clk)
        disable iff (sys_rst) single_take |=> resp.valid && core_ready)
        else $error("single access not answered next cycle");

    AST_SRAM_WORD: assert property (@(posedge ref_clk)
        disable iff (sys_rst) sram_acc && !req.write && is_word |=>
        resp.valid && resp.rdata == $past(sram_mem[sram_idx]))
        else $error("SRAM word read wrong or late");

    AST_LOW_HALF: assert property (@(posedge ref_clk)
        disable iff (sys_rst) flash_word_take |-> ##2
        resp.rdata[15:0] == $past(flash_mem[lo_idx], 2))
        else $error("low flash halfword not in low half");

    AST_ERASE_LEN: assert property (@(posedge ref_clk)
        disable iff (sys_rst) erase_go |=> prog_busy [*8])
        else $error("page erase ended early");

    AST_KERNEL_SAFE: assert property (@(posedge ref_clk)
        disable iff (sys_rst) prog_take && !prog_user |=> !prog_busy)
        else $error("kernel area accepted for programming");

endmodule : mem_subsystem

`default_nettype wire

// ---- testbench/core_model.sv ----
// Core-side bus master model for the memory subsystem.
// Assumes one clock; requests change only on the falling edge.
`default_nettype none

module core_model
(
    input wire logic ref_clk,
    input wire logic core_ready,
    input wire mem_map_pkg::core_resp_s resp,
    output var mem_map_pkg::core_req_s req
);
    timeunit 1ns;
    timeprecision 100ps;

    initial req = '0;

    // Hold a request until taken, release it, then count cycles to answer
    task automatic xfer(input logic wr, input mem_map_pkg::size_e sz,
        input logic [31:0] a, input logic [31:0] wd,
        output mem_map_pkg::core_resp_s rs, output int lat);
        int n;
        n = 0;
        lat = 1;
        @(negedge ref_clk);
        req <= {1'b1, wr, sz, a, wd};
        while (core_ready !== 1'b1 && n < 300)
        begin
            @(negedge ref_clk);
            n++;
        end
        @(negedge ref_clk);
        req <= {1'b0, ~wr, sz, ~a, ~wd}; // Released lines other than size show no stale value
        // The answer stands one cycle, so look from the release edge on
        while (resp.valid !== 1'b1 && lat < 300)
        begin
            @(negedge ref_clk);
            lat++;
        end
        rs = resp;
        if (n >= 300 || lat >= 300)
            lat = -1;
    endtask : xfer

endmodule : core_model

`default_nettype wire

// ---- testbench/mem_subsystem_tb.sv ----
// Self-checking bench for the memory subsystem against a reference model.
// Assumes flash contents are set through the programming port first.
`default_nettype none

module mem_subsystem_tb;
    timeunit 1ns;
    timeprecision 100ps;

    logic ref_clk, sys_rst, alias_wr, alias_bit0;
    logic core_ready, prog_busy, alias_is_flash, al_flash;
    mem_map_pkg::core_req_s req;
    mem_map_pkg::core_resp_s resp, rs;
    mem_map_pkg::prog_cmd_s prog;
    int bad_count, num_checks, seed, lat;
    logic [15:0] fl [int];
    logic [31:0] sr [int];
    logic [31:0] a;

    mem_subsystem dut (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .alias_wr(alias_wr), .alias_bit0(alias_bit0), .req(req),
        .resp(resp), .core_ready(core_ready), .prog(prog),
        .prog_busy(prog_busy), .alias_is_flash(alias_is_flash));
    core_model u_core (.ref_clk(ref_clk), .core_ready(core_ready),
        .resp(resp), .req(req));

    // Core clock, 4 ns period
    initial
    begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end

    // Verdict and end of run
    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : complete_run

    // One comparison
    task automatic check(string what, logic [31:0] e, logic [31:0] g);
        num_checks++;
        if (g !== e)
        begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", what, e, g);
        end
    endtask : check

    // Expected {is_flash, err, rdata} for a read
    function automatic logic [33:0] ref_rd(logic [31:0] x,
        mem_map_pkg::size_e sz);
        logic [14:0] h;
        h = x[15:1];
        if (x[31:16] == 16'h0008 || (x[31:16] == 16'h0 && al_flash))
        begin
            if (sz == mem_map_pkg::SZ_WORD)
                return {2'b10, fl[{h[14:1], 1'b1}], fl[{h[14:1], 1'b0}]};
            return {2'b10, fl[h], fl[h]};
        end
        if (x[31:16] == 16'h0 || x[31:13] == 19'h00008)
            return {2'b00, sr.exists(x[12:2]) ? sr[x[12:2]] : 32'h0};
        return {2'b01, 32'h0};
    endfunction : ref_rd

    // One core access checked against the reference
    task automatic acc(logic wr, mem_map_pkg::size_e sz, logic [31:0] x);
        logic [31:0] wd;
        logic [33:0] e;
        logic [3:0] ln;
        wd = $random(seed);
        e = ref_rd(x, sz);
        u_core.xfer(wr, sz, x, wd, rs, lat);
        if (lat < 0)
        begin
            bad_count++;
            complete_run();
        end
        check("latency", (e[33] && !wr && sz == mem_map_pkg::SZ_WORD) ? 2 : 1,
            lat);
        check("err", {31'h0, e[32] | (wr & e[33])}, {31'h0, rs.err});
        if (!wr)
            check("rdata", e[31:0], rs.rdata);
        else if (!e[32] && !e[33])
        begin
            ln = (sz == mem_map_pkg::SZ_WORD) ? 4'hF :
                (sz == mem_map_pkg::SZ_HALF) ? (x[1] ? 4'hC : 4'h3) :
                4'h1 << x[1:0];
            for (int i = 0; i < 4; i++)
                if (ln[i])
                    e[8*i +: 8] = wd[8*i +: 8];
            sr[x[12:2]] = e[31:0];
        end
    endtask : acc

    // One programming command; erase waits out the busy period
    task automatic prog_hw(logic er, logic [14:0] h, logic [15:0] d);
        int n;
        n = 0;
        @(negedge ref_clk);
        prog <= {1'b1, er, h, d};
        @(negedge ref_clk);
        prog.valid <= 1'b0;
        if (!er && h < mem_map_pkg::KERNEL_FIRST)
            fl[h] = d;
        else if (er)
        begin
            // Kernel pages are refused: no busy period, contents kept
            if (h < mem_map_pkg::KERNEL_FIRST)
                for (int i = 0; i < 256; i++)
                    fl[{h[14:8], i[7:0]}] = 16'hFFFF;
            while (prog_busy === 1'b1 && n < 400)
            begin
                @(negedge ref_clk);
                n++;
            end
            check("busy cycles", (h < mem_map_pkg::KERNEL_FIRST) ? 256 : 0, n);
            if (n >= 400)
                complete_run();
        end
    endtask : prog_hw

    // Reset the design for two cycles
    task automatic do_reset();
        sys_rst = 1'b1;
        al_flash = 1'b1;
        repeat (2) @(negedge ref_clk);
        sys_rst = 1'b0;
        check("alias_is_flash", 1, alias_is_flash);
    endtask : do_reset

    // Main sequence
    initial
    begin
        seed = 4631;
        bad_count = 0;
        num_checks = 0;
        alias_wr = 1'b0;
        alias_bit0 = 1'b1;
        prog = '0;
        do_reset();
        prog_hw(1'b1, 15'h0200, 16'h0);
        prog_hw(1'b1, 15'h7C00, 16'h0);
        acc(1'b0, mem_map_pkg::SZ_WORD, 32'h0008_05FC);
        for (int i = 0; i < 8; i++)
        begin
            a = $random(seed) & 32'h7AFE;
            prog_hw(1'b0, a[14:0], 16'($random(seed)));
            prog_hw(1'b0, a[14:0] | 15'h1, 16'($random(seed)));
            acc(1'b0, mem_map_pkg::SZ_WORD, 32'h0008_0000 + 2 * a);
            acc(1'b0, mem_map_pkg::SZ_WORD, 2 * a);
            acc(1'b0, mem_map_pkg::SZ_HALF, 32'h0008_0002 + 2 * a);
            acc(1'b0, mem_map_pkg::SZ_BYTE, 2 * a + 1);
            acc(1'b1, mem_map_pkg::SZ_WORD, 2 * a);
        end
        for (int i = 0; i < 6; i++)
        begin
            a = 32'h0001_0000 + (($random(seed) & 32'h7FF) << 2);
            acc(1'b1, mem_map_pkg::SZ_WORD, a);
            acc(1'b1, mem_map_pkg::SZ_BYTE, a + 1);
            acc(1'b1, mem_map_pkg::SZ_HALF, a + 2);
            acc(1'b0, mem_map_pkg::SZ_WORD, a);
        end
        acc(1'b0, mem_map_pkg::SZ_WORD, 32'h0002_0000);
        @(negedge ref_clk);
        alias_wr <= 1'b1;
        alias_bit0 <= 1'b0;
        @(negedge ref_clk);
        alias_wr <= 1'b0;
        al_flash = 1'b0;
        @(negedge ref_clk);
        check("alias_is_flash", 0, alias_is_flash);
        acc(1'b0, mem_map_pkg::SZ_WORD, {19'h0, a[12:0]});
        do_reset();
        complete_run();
    end

endmodule : mem_subsystem_tb

`default_nettype wire
